// file: src/ljbc_pkg.sv
// How it works
// - ON skip condition: run on normally
// - OFF skip: jump, leave everything between untouched
// - Jump numbers 00..99, 00 means shared
// - Unique skip resumes at matching skip end
// - Shared skip resumes after next shared end
// - Shared skip searches forward, so slower
// - Rising pulse: one scan after OFF-to-ON
// - Falling pulse: one scan after ON-to-OFF
// - Pulse clears on next execution
// - Latch set line ON drives bit ON unless reset line ON
// - Latch reset line ON drives bit OFF
// - Latch holds inside gated-off section
// - Sealed output clears when gate OFF
// - Gate OFF runs section with OFF condition
`default_nettype none
package ljbc_pkg;

  // ***************
  // Encodings
  // ***************
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_LOAD = 4'h1,
    OP_LOAD_NOT = 4'h2,
    OP_AND = 4'h3,
    OP_AND_NOT = 4'h4,
    OP_OR = 4'h5,
    OP_OR_NOT = 4'h6,
    OP_OUT = 4'h7,
    OP_OUT_NOT = 4'h8,
    OP_SECTION_SKIP = 4'h9,
    OP_SECTION_SKIP_END = 4'ha,
    OP_RISING_EDGE_PULSE = 4'hb,
    OP_FALLING_EDGE_PULSE = 4'hc,
    OP_LATCH = 4'hd,
    OP_SECTION_GATE = 4'he,
    OP_END = 4'hf
  } ljbc_op_t;

  typedef struct packed {
    ljbc_op_t op;
    logic [11:0] arg;
  } ljbc_instr_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PRESCAN = 3'b001,
    ST_RUN = 3'b010,
    ST_SEARCH = 3'b011,
    ST_REFRESH = 3'b100,
    ST_GATE_CLR = 3'b101
  } ljbc_state_t;

  // ***************
  // Layout
  // ***************
  localparam int BIT_AW = 8;
  localparam int JUMP_W = 7;
  localparam logic [JUMP_W-1:0] SHARED_JUMP_NUM = 7'h00;
  localparam logic [JUMP_W-1:0] MAX_JUMP_NUM = 7'h63;
  localparam logic [11:0] GATE_CLR_ARG = 12'hfff;
  localparam logic [BIT_AW-1:0] IN_BIT_LIMIT = 8'h10;
  localparam int IN_BIT_COUNT = 16;
  localparam int OUT_BIT_BASE = 16;
  localparam int OUT_BIT_COUNT = 16;
  localparam logic RESET_BIT = 1'b0;

  function automatic logic isSharedNum(input logic [JUMP_W-1:0] n);
    return n == SHARED_JUMP_NUM;
  endfunction : isSharedNum

  function automatic logic isUniqueNum(input logic [JUMP_W-1:0] n);
    return (n != SHARED_JUMP_NUM) && (n <= MAX_JUMP_NUM);
  endfunction : isUniqueNum

  function automatic logic isInputAddr(input logic [BIT_AW-1:0] a);
    return a < IN_BIT_LIMIT;
  endfunction : isInputAddr

endpackage : ljbc_pkg
`default_nettype wire

// file: src/ljbc_prog_mem.sv
`timescale 1ns/100ps
`default_nettype none
module ljbc_prog_mem
  import ljbc_pkg::*;
#(
  parameter int PROG_AW = 10
) (
  input wire logic core_clk,
  input wire logic wrEn,
  input wire logic [PROG_AW-1:0] wrAddr,
  input wire ljbc_instr_t wrData,
  input wire logic [PROG_AW-1:0] rdAddr,
  output ljbc_instr_t rdData
);

  // ***************
  // Storage
  // ***************
  // Unreset on purpose: contents come from the loader
  ljbc_instr_t mem [2**PROG_AW];

  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  assign rdData = mem[rdAddr];

endmodule : ljbc_prog_mem
`default_nettype wire

// file: src/ljbc_scan_engine.sv
`timescale 1ns/100ps
`default_nettype none
module ljbc_scan_engine
  import ljbc_pkg::*;
#(
  parameter int PROG_AW = 10
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic runEn,
  input wire logic progWrEn,
  input wire logic [PROG_AW-1:0] progWrAddr,
  input wire ljbc_instr_t progWrData,
  input wire logic [IN_BIT_COUNT-1:0] inPins,
  output logic [OUT_BIT_COUNT-1:0] outPins,
  output logic scanDone,
  output logic running
);

  // ***************
  // State
  // ***************
  localparam int PROG_DEPTH = 2**PROG_AW;
  localparam int BIT_DEPTH = 2**BIT_AW;

  ljbc_state_t state_reg, state_next;
  logic [PROG_AW-1:0] pc_reg, pc_next;
  logic acc_reg, save_reg, gateOn_reg;
  logic [BIT_DEPTH-1:0] bitVec_reg;
  logic [PROG_DEPTH-1:0] prevCond_reg;
  logic [(2**JUMP_W)-1:0] endValid_reg;
  logic [PROG_AW-1:0] endAddr_reg [2**JUMP_W];
  logic [IN_BIT_COUNT-1:0] inMeta_reg, inSync_reg;
  logic [OUT_BIT_COUNT-1:0] outPins_reg;
  logic scanDone_reg, running_reg;
  ljbc_instr_t instr;

  ljbc_prog_mem #(.PROG_AW(PROG_AW)) u_prog (
    .core_clk(core_clk),
    .wrEn(progWrEn),
    .wrAddr(progWrAddr),
    .wrData(progWrData),
    .rdAddr(pc_reg),
    .rdData(instr)
  );

  // ***************
  // Decode
  // ***************
  wire ljbc_op_t op = instr.op;
  wire logic [BIT_AW-1:0] bitAddr = instr.arg[BIT_AW-1:0];
  wire logic [JUMP_W-1:0] jumpNum = instr.arg[JUMP_W-1:0];
  wire logic shared = isSharedNum(jumpNum);
  wire logic uniqueNum = isUniqueNum(jumpNum);
  wire logic inRun = state_reg == ST_RUN;
  wire logic isProgEnd = (op == OP_END) || (pc_reg == PROG_AW'('1));
  wire logic isGateClr = (op == OP_SECTION_GATE) && (instr.arg == GATE_CLR_ARG);
  wire logic opBit = isInputAddr(bitAddr) ? inSync_reg[bitAddr[3:0]] : bitVec_reg[bitAddr];
  // Gate OFF forces every right-hand instruction to see OFF
  wire logic effCond = acc_reg & gateOn_reg;
  wire logic latchSet = save_reg & gateOn_reg;
  wire logic prevCond = prevCond_reg[pc_reg];
  wire logic riseBit = effCond & ~prevCond;
  wire logic fallBit = ~effCond & prevCond;
  // Reset checked first so it wins over set; neither line keeps the bit
  wire logic latchBit = effCond ? RESET_BIT : (latchSet ? 1'b1 : opBit);
  wire logic isBitOp = (op == OP_OUT) || (op == OP_OUT_NOT) || (op == OP_LATCH)
    || (op == OP_RISING_EDGE_PULSE) || (op == OP_FALLING_EDGE_PULSE);
  wire logic isEdgeOp = (op == OP_RISING_EDGE_PULSE) || (op == OP_FALLING_EDGE_PULSE);
  // Input image is read-only; stray writes there are dropped
  wire logic bitWe = inRun && isBitOp && !isInputAddr(bitAddr);
  wire logic bitWd = (op == OP_OUT) ? effCond :
    (op == OP_OUT_NOT) ? ~effCond :
    (op == OP_RISING_EDGE_PULSE) ? riseBit :
    (op == OP_FALLING_EDGE_PULSE) ? fallBit : latchBit;
  wire logic skipTaken = inRun && (op == OP_SECTION_SKIP) && !effCond;
  wire logic [PROG_AW-1:0] targetAddr = endAddr_reg[jumpNum];
  wire logic targetValid = endValid_reg[jumpNum];
  wire logic isCondOp = (op >= OP_LOAD) && (op <= OP_OR_NOT);
  wire logic condOut = (op == OP_LOAD) ? opBit :
    (op == OP_LOAD_NOT) ? ~opBit :
    (op == OP_AND) ? (acc_reg & opBit) :
    (op == OP_AND_NOT) ? (acc_reg & ~opBit) :
    (op == OP_OR) ? (acc_reg | opBit) : (acc_reg | ~opBit);
  wire logic isLoad = (op == OP_LOAD) || (op == OP_LOAD_NOT);
  wire logic recordEnd = (state_reg == ST_PRESCAN) && (op == OP_SECTION_SKIP_END) && uniqueNum;

  // ***************
  // Sequencer
  // ***************
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    case (state_reg)
      ST_IDLE: begin
        pc_next = '0;
        if (runEn) begin
          state_next = ST_PRESCAN;
        end
      end
      ST_PRESCAN: begin
        pc_next = pc_reg + 1'b1;
        if (isProgEnd) begin
          pc_next = '0;
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        pc_next = pc_reg + 1'b1;
        if (isProgEnd) begin
          pc_next = pc_reg;
          state_next = ST_REFRESH;
        end else if (skipTaken && shared) begin
          state_next = ST_SEARCH;
        end else if (skipTaken && targetValid) begin
          pc_next = targetAddr;
        end else if (skipTaken) begin
          // No matching end: rest of the scan is skipped
          pc_next = pc_reg;
          state_next = ST_REFRESH;
        end
      end
      ST_SEARCH: begin
        // One instruction per cycle, hence slower than a unique skip
        pc_next = pc_reg + 1'b1;
        if ((op == OP_SECTION_SKIP_END) && shared) begin
          state_next = ST_RUN;
        end else if (isProgEnd) begin
          pc_next = pc_reg;
          state_next = ST_REFRESH;
        end
      end
      ST_REFRESH: begin
        pc_next = '0;
        state_next = runEn ? ST_RUN : ST_IDLE;
      end
      default: begin
        pc_next = '0;
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      pc_reg <= '0;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
    end
  end

  // ***************
  // Condition path
  // ***************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg <= 1'b0;
      save_reg <= 1'b0;
      gateOn_reg <= 1'b1;
    end else if (state_reg == ST_REFRESH) begin
      acc_reg <= 1'b0;
      gateOn_reg <= 1'b1;
    end else if (inRun && isCondOp) begin
      acc_reg <= condOut;
      if (isLoad) begin
        save_reg <= acc_reg;
      end
    end else if (inRun && isGateClr) begin
      gateOn_reg <= 1'b1;
    end else if (inRun && (op == OP_SECTION_GATE)) begin
      gateOn_reg <= effCond;
    end
  end

  // ***************
  // Bit image
  // ***************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bitVec_reg <= '0;
      prevCond_reg <= '0;
    end else begin
      if (bitWe) begin
        bitVec_reg[bitAddr] <= bitWd;
      end
      if (inRun && isEdgeOp) begin
        prevCond_reg[pc_reg] <= effCond;
      end
    end
  end

  // Duplicate unique numbers: last end in the program wins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      endValid_reg <= '0;
    end else if (state_reg == ST_IDLE) begin
      endValid_reg <= '0;
    end else if (recordEnd) begin
      endValid_reg[jumpNum] <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (recordEnd) begin
      endAddr_reg[jumpNum] <= pc_reg;
    end
  end

  // ***************
  // Pins
  // ***************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      inMeta_reg <= '0;
      inSync_reg <= '0;
      outPins_reg <= '0;
      scanDone_reg <= 1'b0;
      running_reg <= 1'b0;
    end else begin
      inMeta_reg <= inPins;
      inSync_reg <= inMeta_reg;
      scanDone_reg <= state_reg == ST_REFRESH;
      // Taken from next state so it moves with the state register
      running_reg <= state_next != ST_IDLE;
      if (state_reg == ST_REFRESH) begin
        outPins_reg <= bitVec_reg[OUT_BIT_BASE +: OUT_BIT_COUNT];
      end
    end
  end

  assign outPins = outPins_reg;
  assign scanDone = scanDone_reg;
  assign running = running_reg;

  // ***************
  // Checks
  // ***************
  AST_SKIP_NOT_TAKEN: assert property (@(posedge core_clk) disable iff (!nrst)
    inRun && (op == OP_SECTION_SKIP) && effCond && !isProgEnd
    |=> (state_reg == ST_RUN) && (pc_reg == $past(pc_reg) + 1'b1))
    else $error("Skip with ON condition changed flow");
  AST_SKIP_FREEZES: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == ST_SEARCH) |=> (bitVec_reg == $past(bitVec_reg)))
    else $error("Bit image changed while skipping");
  AST_UNIQUE_TARGET: assert property (@(posedge core_clk) disable iff (!nrst)
    skipTaken && !shared && targetValid && !isProgEnd
    |=> (pc_reg == $past(targetAddr)) && (state_reg == ST_RUN))
    else $error("Unique skip missed its end");
  AST_SHARED_SEARCH: assert property (@(posedge core_clk) disable iff (!nrst)
    skipTaken && shared && !isProgEnd |=> (state_reg == ST_SEARCH))
    else $error("Shared skip did not search");
  AST_SHARED_RESUME: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == ST_SEARCH) && (op == OP_SECTION_SKIP_END) && shared
    |=> (state_reg == ST_RUN) && (pc_reg == $past(pc_reg) + 1'b1))
    else $error("Shared skip resumed at wrong place");
  AST_RISE_PULSE: assert property (@(posedge core_clk) disable iff (!nrst)
    bitWe && (op == OP_RISING_EDGE_PULSE)
    |=> bitVec_reg[$past(bitAddr)] == ($past(effCond) && !$past(prevCond)))
    else $error("Rising pulse wrong");
  AST_FALL_PULSE: assert property (@(posedge core_clk) disable iff (!nrst)
    bitWe && (op == OP_FALLING_EDGE_PULSE)
    |=> bitVec_reg[$past(bitAddr)] == (!$past(effCond) && $past(prevCond)))
    else $error("Falling pulse wrong");
  AST_PULSE_CLEARS: assert property (@(posedge core_clk) disable iff (!nrst)
    bitWe && (op == OP_RISING_EDGE_PULSE) && prevCond |=> !bitVec_reg[$past(bitAddr)])
    else $error("Pulse not cleared on next execution");
  AST_LATCH_RESET: assert property (@(posedge core_clk) disable iff (!nrst)
    bitWe && (op == OP_LATCH) && effCond |=> !bitVec_reg[$past(bitAddr)])
    else $error("Latch reset did not win");
  AST_LATCH_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    bitWe && (op == OP_LATCH) && !gateOn_reg
    |=> bitVec_reg[$past(bitAddr)] == $past(opBit))
    else $error("Latch lost state under gate");
  AST_GATE_CLEARS_OUT: assert property (@(posedge core_clk) disable iff (!nrst)
    bitWe && (op == OP_OUT) && !gateOn_reg |=> !bitVec_reg[$past(bitAddr)])
    else $error("Output not cleared under gate");

endmodule : ljbc_scan_engine
`default_nettype wire

// file: tb/ljbc_prog_model.sv
`timescale 1ns/100ps
`default_nettype none
module ljbc_prog_model
  import ljbc_pkg::*;
#(
  parameter int PROG_AW = 10
) (
  input wire logic core_clk,
  input wire logic loadReq,
  output logic progWrEn,
  output logic [PROG_AW-1:0] progWrAddr,
  output ljbc_instr_t progWrData,
  output logic loadDone
);
  // ***************
  // Program image
  // ***************
  // Condition lines before each controlled instruction
  // Bit instructions end their line, one bit operand
  // Unique numbers 05 used once each way, 00 shared
  // Skip words carry only the jump number
  // Work bits 16..31 only, never inputs
  localparam int N_WORDS = 39;
  localparam logic [15:0] PROG [N_WORDS] = '{
    16'h1000, 16'hb010, 16'h1000, 16'hc011, // Edge pulses
    16'h1001, 16'h1002, 16'hd012, // Latch
    16'h1003, 16'h9005, 16'h1004, 16'h7013, 16'ha005, // Unique skip
    16'h1005, 16'h9000, 16'h1006, 16'h9000, 16'h1007, 16'h7014, 16'ha000,
    16'h1008, 16'h7015, // Always after shared end
    16'h1009, 16'he000, 16'h100a, 16'h5016, 16'h400b, 16'h7016, // Seal
    16'h100c, 16'h100d, 16'hd017, 16'hefff, // Latch under gate
    16'h200e, 16'h300f, 16'h8018, 16'h100e, 16'h600f, 16'h7019, // Inverted forms
    16'h0000, 16'hf000};

  // ***************
  // Loader
  // ***************
  initial begin
    progWrEn = 1'b0;
    progWrAddr = '0;
    progWrData = '0;
    loadDone = 1'b0;
    forever begin
      @(posedge core_clk);
      if (loadReq === 1'b1) begin
        loadDone <= 1'b0;
        for (int i = 0; i < N_WORDS; i++) begin
          progWrEn <= 1'b1;
          progWrAddr <= PROG_AW'(i);
          progWrData <= PROG[i];
          @(posedge core_clk);
        end
        progWrEn <= 1'b0;
        // Stale data flips so nothing leans on it
        progWrData <= ~PROG[N_WORDS-1];
        loadDone <= 1'b1;
      end
    end
  end
endmodule : ljbc_prog_model
`default_nettype wire

// file: tb/ladder_jump_and_bit_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
module ladder_jump_and_bit_control_bench import ljbc_pkg::*;;
  logic core_clk, nrst, runEn, loadReq, loadDone, progWrEn, scanDone, running;
  logic [9:0] progWrAddr;
  ljbc_instr_t progWrData;
  logic [15:0] inPins, outPins;
  logic [15:0] expQ [$];
  logic [31:0] seed;
  logic prev0, k18, b19, b20, b22, k23;
  int n_fail, checks, cycles;

  ljbc_scan_engine #(.PROG_AW(10)) dut (.core_clk(core_clk), .nrst(nrst),
    .runEn(runEn), .progWrEn(progWrEn), .progWrAddr(progWrAddr),
    .progWrData(progWrData), .inPins(inPins), .outPins(outPins),
    .scanDone(scanDone), .running(running));
  ljbc_prog_model #(.PROG_AW(10)) prog (.core_clk(core_clk), .loadReq(loadReq),
    .progWrEn(progWrEn), .progWrAddr(progWrAddr), .progWrData(progWrData),
    .loadDone(loadDone));

  // ***************
  // Helpers
  // ***************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t outPins %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic load();
    loadReq <= 1'b1;
    @(posedge core_clk);
    loadReq <= 1'b0;
    @(posedge core_clk);
    for (int w = 0; w < 100 && loadDone !== 1'b1; w++) @(posedge core_clk);
  endtask : load

  // One scan per run request, inputs held steady across it
  task automatic scan(input logic [15:0] v);
    logic [15:0] e;
    e = '0;
    e[0] = v[0] & ~prev0;
    e[1] = ~v[0] & prev0;
    prev0 = v[0];
    if (v[2]) k18 = 1'b0;
    else if (v[1]) k18 = 1'b1;
    if (v[3]) b19 = v[4];
    if (v[5] & v[6]) b20 = v[7];
    e[5] = v[8];
    b22 = v[9] & (v[10] | b22) & ~v[11];
    if (v[9] & v[13]) k23 = 1'b0;
    else if (v[9] & v[12]) k23 = 1'b1;
    e[2] = k18;
    e[3] = b19;
    e[4] = b20;
    e[6] = b22;
    e[7] = k23;
    e[8] = ~(~v[14] & v[15]);
    e[9] = v[14] | ~v[15];
    expQ.push_back(e);
    inPins <= v;
    repeat (4) @(posedge core_clk);
    runEn <= 1'b1;
    for (int w = 0; w < 50 && running !== 1'b1; w++) @(posedge core_clk);
    runEn <= 1'b0;
    for (int w = 0; w < 500 && running !== 1'b0; w++) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
  endtask : scan

  task automatic hw_reset();
    nrst <= 1'b0;
    {prev0, k18, b19, b20, b22, k23} = '0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    chk(outPins, 16'h0000);
    load();
  endtask : hw_reset

  // ***************
  // Checking
  // ***************
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_fail++;
      $display("[ERR] %0t timeout", $time);
      results();
    end else if (scanDone === 1'b1) begin
      checks++;
      if (running !== 1'b0) begin
        n_fail++;
        $display("[ERR] %0t engine still running after last scan", $time);
      end
      if (expQ.size() == 0) begin
        n_fail++;
        $display("[ERR] %0t unexpected scan end", $time);
      end else begin
        chk(outPins, expQ.pop_front());
      end
    end
  end

  // ***************
  // Stimulus
  // ***************
  localparam logic [15:0] DIR [12] = '{16'h0001, 16'h0001, 16'h0000, 16'h0000,
    16'h0006, 16'h0002, 16'h0018, 16'h0000, 16'h26e0, 16'h3600, 16'h1200, 16'h2000};
  initial begin
    nrst = 1'b0;
    runEn = 1'b0;
    loadReq = 1'b0;
    inPins = '0;
    n_fail = 0;
    checks = 0;
    cycles = 0;
    seed = 32'h3d32c364;
    hw_reset();
    foreach (DIR[i]) scan(DIR[i]);
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 60; i++) begin
        seed = xs(seed);
        scan(seed[15:0]);
      end
      // Second reset mid-run must clear the whole image
      if (r == 0) hw_reset();
    end
    repeat (4) @(posedge core_clk);
    if (expQ.size() != 0) begin
      n_fail++;
      $display("[ERR] %0t scans missing", $time);
    end
    results();
  end
endmodule : ladder_jump_and_bit_control_bench
`default_nettype wire
